// *** common/aro_consts.svh ***
// Purpose: constants for the output routing and modulation block
// Assumes: one clock, synchronous active-high reset
// Notes: sample values are signed q1.15
`ifndef ARO_CONSTS_SVH
`define ARO_CONSTS_SVH
`define ARO_SAMPLE_W       16
`define ARO_PHASE_W        32
`define ARO_HARM_W         8
`define ARO_WAIT_W         32
`define ARO_FIFO_DEPTH     16
`define ARO_FIFO_AW        4
`define ARO_Q_SHIFT        15
`define ARO_LUT_AW         5
`define ARO_SAT_MAX        16'h7fff
`define ARO_SAT_MIN        16'h8000
`define ARO_DFLT_MASK1     2'b01
`define ARO_DFLT_MASK2     2'b10
`define ARO_SEQ_PERIOD_PS  3330
`define ARO_CLK_PERIOD_PS  20000
`define ARO_RESET_AMP      16'h7fff
`endif

// *** common/aro_pkg.sv ***
// Purpose: types for the output routing and modulation block
// Assumes: aro_consts.svh gives the sample width
// Notes: channel index 0 means wave output 1, 1 means wave output 2
`include "aro_consts.svh"
package aro_pkg;
   typedef logic signed [`ARO_SAMPLE_W-1:0] aro_sample_t;
   typedef logic [1:0]                      aro_mask_t;
   typedef enum logic { ARO_DIRECT, ARO_MODULATED } aro_mode_t;
   typedef enum logic { ARO_IDLE, ARO_WAITING } aro_wait_state_t;
   typedef struct packed {
      logic [1:0] n_idx;
      logic       idx_a;
      logic       idx_b;
   } aro_operand_t;
   typedef struct packed {
      logic         two_waves;
      aro_operand_t op1;
      aro_operand_t op2;
   } aro_play_t;
   typedef struct packed {
      aro_sample_t ch2;
      aro_sample_t ch1;
   } aro_chan_pair_t;
endpackage

// *** test/aro_conv_model.sv ***
// Purpose: output converter model draining the sample fifo
// Assumes: converters may stall or take one word every other cycle
// Notes: got_q pulses one cycle per word taken
`timescale 1ns/1ns
module aro_conv_model (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    stall,
   input  wire logic                    slow,
   input  wire logic                    out_valid,
   input  wire aro_pkg::aro_chan_pair_t out_data,
   output logic                         out_ready,
   output logic                         got_q,
   output aro_pkg::aro_chan_pair_t      word_q
);
   import aro_pkg::*;
   logic tog_q;
   // slow pace exposes a fifo that assumes a pop every cycle
   assign out_ready = !stall && !(slow && tog_q);
   always_ff @(posedge clk) begin
      tog_q <= reset ? 1'b0 : !tog_q;
   end
   always_ff @(posedge clk) begin
      got_q <= out_valid && out_ready && !reset;
      if (out_valid && out_ready) word_q <= out_data;
   end
endmodule

// *** test/aro_output_routing_sva.sv ***
// Purpose: port-level checks of routing, wait and play handshake
// Assumes: one clock, synchronous active-high reset
// Notes: sample mixing is judged by the bench, not here
`timescale 1ns/1ns
`include "aro_consts.svh"
module aro_output_routing_chk (
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic                   play_valid,
   input wire logic                   play_ready,
   input wire aro_pkg::aro_play_t     play_instr,
   input wire logic                   wait_valid,
   input wire logic [`ARO_WAIT_W-1:0] wait_cycles,
   input wire logic                   wait_busy,
   input wire aro_pkg::aro_mask_t     route_mask1,
   input wire aro_pkg::aro_mask_t     route_mask2
);
   import aro_pkg::*;
   aro_play_t p_q;
   logic      take;
   assign take = play_valid && play_ready;
   // routing lands one cycle after the take, so keep the taken operands
   always_ff @(posedge clk) p_q <= play_instr;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ready_busy_a: assert property (play_ready != wait_busy)
      else $error("play ready disagrees with wait");
   wait_two_a: assert property (wait_valid && !wait_busy && wait_cycles == 32'h2
      |=> wait_busy[*2] ##1 !wait_busy) else $error("wait of two wrong");
   wait_five_a: assert property (wait_valid && !wait_busy && wait_cycles == 32'h5
      |=> wait_busy[*5] ##1 !wait_busy) else $error("wait of five wrong");
   one_wave_a: assert property (take && !play_instr.two_waves && play_instr.op1.n_idx == 2'h0
      |=> route_mask1 == 2'h1 && route_mask2 == 2'h0) else $error("single route wrong");
   index_route_a: assert property (take && play_instr.op1.n_idx == 2'h1
      |=> route_mask1 == (p_q.op1.idx_a ? 2'h2 : 2'h1)) else $error("indexed route wrong");
   dual_route_a: assert property (take && play_instr.op1.n_idx >= 2'h2
      |=> route_mask1 == ((2'h1 << p_q.op1.idx_a) | (2'h1 << p_q.op1.idx_b)))
      else $error("dual route wrong");
   second_wave_a: assert property (take && play_instr.two_waves && play_instr.op2.n_idx == 2'h0
      |=> route_mask2 == 2'h2) else $error("second wave route wrong");
   sum_route_a: assert property (take && play_instr.two_waves && play_instr.op1.n_idx == 2'h1
      && play_instr.op2.n_idx == 2'h1 && play_instr.op1.idx_a == play_instr.op2.idx_a
      |=> route_mask1 == route_mask2) else $error("summed route wrong");
   route_hold_a: assert property (!take |=> $stable(route_mask1) && $stable(route_mask2))
      else $error("route changed without play");
   cover property (take && play_instr.two_waves);
   cover property (take && play_instr.op1.n_idx >= 2'h2);
   cover property (wait_busy ##1 !wait_busy);
endmodule
bind aro_output_routing aro_output_routing_chk u_chk (.clk, .reset, .play_valid, .play_ready,
   .play_instr, .wait_valid, .wait_cycles, .wait_busy, .route_mask1, .route_mask2);

// *** test/tb_aro_output_routing.sv ***
// Purpose: self-checking bench for output routing and modulation
// Assumes: oscillators advance in one counted burst, so carriers stay known
// Notes: full scale held at 7fff, so amp = sample*32767>>15
`timescale 1ns/1ns
module tb_aro_output_routing;
   import aro_pkg::*;
   logic           clk, reset, play_valid, wait_valid, sample_valid, stall, slow, mf;
   logic           play_ready, wait_busy, sample_ready, out_valid, out_ready, got_q;
   logic [31:0]    wait_cycles, osc, osc_b;
   logic [15:0]    offs1;
   logic [7:0]     harm;
   logic [1:0]     mod_sel1, mod_sel2, osel;
   aro_mask_t      route_mask1, route_mask2;
   aro_play_t      play_instr;
   aro_sample_t    s1, s2, fs;
   aro_mode_t      mode1, mode2;
   aro_chan_pair_t out_data, word_q;
   int             mismatches, check_count, n;
   int             wl[3] = '{0, 2, 5};
   aro_play_t      pl[6] = '{9'h000, 9'h060, 9'h090, 9'h100, 9'h144, 9'h164};
   logic [3:0]     mk[6] = '{4'h4, 4'h8, 4'hc, 4'h6, 4'h5, 4'h9};
   logic [31:0]    ex[6] = '{32'h0000_3fff, 32'h3fff_0000, 32'h3fff_3fff,
                             32'h1fff_3fff, 32'h0000_5ffe, 32'h3fff_1fff};
   aro_output_routing DUT (.clk, .reset, .play_valid, .play_ready, .play_instr,
      .wait_valid, .wait_cycles, .wait_busy, .sample_valid, .sample_ready,
      .core_sample1(s1), .core_sample2(s2), .full_scale_amplitude1(fs),
      .full_scale_amplitude2(fs), .mode1, .mode2, .mod_sel1, .mod_sel2,
      .osc_freq1(osc), .osc_freq2(osc_b), .multi_freq_present(mf), .sine_osc_sel(osel),
      .sine_phase_offset1(offs1), .sine_phase_offset2(16'h0000), .sine_harmonic1(harm),
      .sine_harmonic2(harm), .route_mask1, .route_mask2, .out_valid, .out_ready, .out_data);
   aro_conv_model conv (.clk, .reset, .stall, .slow, .out_valid, .out_data, .out_ready,
      .got_q, .word_q);
   function automatic logic [15:0] amp(input int x);
      return 16'((x * 32767) >>> 15);
   endfunction
   task automatic summarize;
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bound(input int k);
      if (k >= 50) begin
         mismatches++;
         summarize();
      end
   endtask
   // holds the request until the ready seen at the negedge is sampled
   task automatic hs(input bit k);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((k ? sample_ready : play_ready) !== 1'b1 && n < 50);
      bound(n);
      @(posedge clk);
   endtask
   task automatic play(input aro_play_t p);
      @(posedge clk);
      play_valid <= 1'b1;
      play_instr <= p;
      hs(1'b0);
      play_valid <= 1'b0;
   endtask
   task automatic push(input aro_sample_t a, input aro_sample_t b);
      @(posedge clk);
      sample_valid <= 1'b1;
      s1 <= a;
      s2 <= b;
      hs(1'b1);
      sample_valid <= 1'b0;
   endtask
   task automatic pull(input logic [31:0] e);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (got_q !== 1'b1 && n < 50);
      bound(n);
      check(word_q, e);
   endtask
   task automatic run(input aro_play_t p, input aro_sample_t a, b, input logic [31:0] e);
      play(p);
      push(a, b);
      pull(e);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      {play_valid, wait_valid, sample_valid, stall, slow, mf} = '0;
      {wait_cycles, osc, osc_b, offs1, mod_sel1, mod_sel2, osel, s1, s2, play_instr} = '0;
      mode1 = ARO_DIRECT;
      mode2 = ARO_DIRECT;
      harm = 8'h01;
      fs = 16'h7fff;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      check({route_mask1, route_mask2}, 32'h6);
      foreach (pl[i]) begin
         run(pl[i], 16'h4000, 16'h2000, ex[i]);
         check({route_mask1, route_mask2}, mk[i]);
      end
      run(9'h144, 16'h7fff, 16'h7fff, 32'h0000_7fff);
      run(9'h144, 16'h8000, 16'h8000, 32'h0000_8000);
      foreach (wl[i]) begin
         @(posedge clk);
         wait_valid <= 1'b1;
         wait_cycles <= 32'(wl[i]);
         @(posedge clk);
         wait_valid <= 1'b0;
         n = 0;
         repeat (12) begin
            @(negedge clk);
            if (wait_busy === 1'b1) n++;
         end
         check(32'(n), 32'(wl[i]));
      end
      // offset 4000 puts sine 1 on its peak, sine 2 stays at zero
      @(posedge clk);
      mode1 <= ARO_MODULATED;
      offs1 <= 16'h4000;
      run(9'h000, 16'h4000, 16'h0000, 32'h0000_3ffe);
      @(posedge clk);
      mod_sel1 <= 2'h1;
      run(9'h000, 16'h4000, 16'h0000, 32'h0000_0000);
      run(9'h060, 16'h4000, 16'h0000, 32'h3ffe_0000);
      @(posedge clk);
      mode1 <= ARO_DIRECT;
      stall <= 1'b1;
      play(9'h100);
      for (int i = 0; i < 16; i++)
         push(16'(i * 1024), 16'h0000);
      @(negedge clk);
      check(32'({sample_ready, out_valid}), 32'h1);
      @(posedge clk);
      stall <= 1'b0;
      slow <= 1'b1;
      for (int i = 0; i < 16; i++)
         pull({16'h0000, amp(i * 1024)});
      check(32'(out_valid), 32'h0);
      // eight steps leave osc 1 at a quarter turn; osc 2 wraps back to zero
      @(posedge clk);
      osc <= 32'h0800_0000;
      osc_b <= 32'h2000_0000;
      offs1 <= 16'h0000;
      mode1 <= ARO_MODULATED;
      mode2 <= ARO_MODULATED;
      mod_sel1 <= 2'h0;
      mod_sel2 <= 2'h2;
      repeat (8) @(posedge clk);
      osc <= 32'h0000_0000;
      osc_b <= 32'h0000_0000;
      run(9'h100, 16'h4000, 16'h4000, 32'h0000_3ffe);
      @(posedge clk);
      mf <= 1'b1;
      osel <= 2'h1;
      run(9'h100, 16'h4000, 16'h4000, 32'h3ffe_0000);
      @(posedge clk);
      mf <= 1'b0;
      harm <= 8'h03;
      run(9'h000, 16'h4000, 16'h4000, 32'h0000_c001);
      // mid-run reset must bring the default routing back
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      check({route_mask1, route_mask2}, 32'h6);
      summarize();
   end
endmodule

// *** verilog/aro_output_routing.sv ***
// Purpose: route and modulate two core outputs onto one wave output pair
// Assumes: converters drain a 16-word fifo with valid and ready
// Notes: sine table holds one period in 32 points, no interpolation
`timescale 1ns/1ns
`include "aro_consts.svh"

module aro_fifo #(
   parameter int WIDTH = 2*`ARO_SAMPLE_W,
   parameter int DEPTH = `ARO_FIFO_DEPTH,
   parameter int AW    = `ARO_FIFO_AW
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// Contract
// - first wave on core out 1, second on 2
// - channel index routes, else default channel
// - mode and amplitude follow the core output
// - two indices drive both channels at once
// - same index on both sums the two outputs
// - core drives only its own channel pair
// - modulation multiplies output by selected sine
// - per-channel choice of sine generator 1 or 2
// - sine from phase, offset, harmonic, one-period table
// - oscillator adds frequency word every clock
// - oscillators run regardless of playback
// - wait stalls for argument clock periods
// - multi-frequency option: any oscillator feeds any sine
module aro_output_routing (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        play_valid,
   output logic                             play_ready,
   input  wire aro_pkg::aro_play_t          play_instr,
   input  wire logic                        wait_valid,
   input  wire logic [`ARO_WAIT_W-1:0]      wait_cycles,
   output logic                             wait_busy,
   input  wire logic                        sample_valid,
   output logic                             sample_ready,
   input  wire aro_pkg::aro_sample_t        core_sample1,
   input  wire aro_pkg::aro_sample_t        core_sample2,
   input  wire aro_pkg::aro_sample_t        full_scale_amplitude1,
   input  wire aro_pkg::aro_sample_t        full_scale_amplitude2,
   input  wire aro_pkg::aro_mode_t          mode1,
   input  wire aro_pkg::aro_mode_t          mode2,
   input  wire logic [1:0]                  mod_sel1,
   input  wire logic [1:0]                  mod_sel2,
   input  wire logic [`ARO_PHASE_W-1:0]     osc_freq1,
   input  wire logic [`ARO_PHASE_W-1:0]     osc_freq2,
   input  wire logic                        multi_freq_present,
   input  wire logic [1:0]                  sine_osc_sel,
   input  wire logic [`ARO_SAMPLE_W-1:0]    sine_phase_offset1,
   input  wire logic [`ARO_SAMPLE_W-1:0]    sine_phase_offset2,
   input  wire logic [`ARO_HARM_W-1:0]      sine_harmonic1,
   input  wire logic [`ARO_HARM_W-1:0]      sine_harmonic2,
   output aro_pkg::aro_mask_t               route_mask1,
   output aro_pkg::aro_mask_t               route_mask2,
   output logic                             out_valid,
   input  wire logic                        out_ready,
   output aro_pkg::aro_chan_pair_t          out_data
);
   import aro_pkg::*;

   aro_mask_t             mask1_q;
   aro_mask_t             mask2_q;
   aro_wait_state_t       wstate_q;
   logic [`ARO_WAIT_W-1:0] wcnt_q;
   logic [`ARO_PHASE_W-1:0] osc1_q;
   logic [`ARO_PHASE_W-1:0] osc2_q;
   aro_sample_t           sine1_q;
   aro_sample_t           sine2_q;
   aro_sample_t           amp1;
   aro_sample_t           amp2;
   aro_sample_t           t11;
   aro_sample_t           t12;
   aro_sample_t           t21;
   aro_sample_t           t22;
   aro_chan_pair_t        mix;
   logic                  fifo_in_ready;

   // one period of the sinusoid, 32 points
   function automatic aro_sample_t sine_lut(input logic [`ARO_LUT_AW-1:0] idx);
      case (idx)
         5'h00: sine_lut = 16'h0000;
         5'h01: sine_lut = 16'h18f9;
         5'h02: sine_lut = 16'h30fb;
         5'h03: sine_lut = 16'h471c;
         5'h04: sine_lut = 16'h5a82;
         5'h05: sine_lut = 16'h6a6d;
         5'h06: sine_lut = 16'h7641;
         5'h07: sine_lut = 16'h7d8a;
         5'h08: sine_lut = 16'h7fff;
         5'h09: sine_lut = 16'h7d8a;
         5'h0a: sine_lut = 16'h7641;
         5'h0b: sine_lut = 16'h6a6d;
         5'h0c: sine_lut = 16'h5a82;
         5'h0d: sine_lut = 16'h471c;
         5'h0e: sine_lut = 16'h30fb;
         5'h0f: sine_lut = 16'h18f9;
         5'h10: sine_lut = 16'h0000;
         5'h11: sine_lut = 16'he707;
         5'h12: sine_lut = 16'hcf05;
         5'h13: sine_lut = 16'hb8e4;
         5'h14: sine_lut = 16'ha57e;
         5'h15: sine_lut = 16'h9593;
         5'h16: sine_lut = 16'h89bf;
         5'h17: sine_lut = 16'h8276;
         5'h18: sine_lut = 16'h8001;
         5'h19: sine_lut = 16'h8276;
         5'h1a: sine_lut = 16'h89bf;
         5'h1b: sine_lut = 16'h9593;
         5'h1c: sine_lut = 16'ha57e;
         5'h1d: sine_lut = 16'hb8e4;
         5'h1e: sine_lut = 16'hcf05;
         5'h1f: sine_lut = 16'he707;
         default: sine_lut = 16'h0000;
      endcase
   endfunction

   // q1.15 product; the single overflowing case is clamped
   function automatic aro_sample_t mul_q15(input aro_sample_t a, input aro_sample_t b);
      logic signed [2*`ARO_SAMPLE_W-1:0] p;
      p = a * b;
      if (a == `ARO_SAT_MIN && b == `ARO_SAT_MIN) begin
         mul_q15 = `ARO_SAT_MAX;
      end else begin
         mul_q15 = p[`ARO_Q_SHIFT +: `ARO_SAMPLE_W];
      end
   endfunction

   function automatic aro_sample_t sat_add(input aro_sample_t a, input aro_sample_t b);
      logic signed [`ARO_SAMPLE_W:0] s;
      s = {a[`ARO_SAMPLE_W-1], a} + {b[`ARO_SAMPLE_W-1], b};
      if (s[`ARO_SAMPLE_W] != s[`ARO_SAMPLE_W-1]) begin
         sat_add = s[`ARO_SAMPLE_W] ? `ARO_SAT_MIN : `ARO_SAT_MAX;
      end else begin
         sat_add = s[`ARO_SAMPLE_W-1:0];
      end
   endfunction

   // index is a single bit, so no core can address a foreign pair
   function automatic aro_mask_t route_of(input aro_operand_t op, input aro_mask_t dflt);
      aro_mask_t m;
      m = 2'h0;
      case (op.n_idx)
         2'h0: m = dflt;
         2'h1: m = 2'(2'h1 << op.idx_a);
         default: m = 2'(2'h1 << op.idx_a) | 2'(2'h1 << op.idx_b);
      endcase
      route_of = m;
   endfunction

   function automatic aro_sample_t sine_of(input logic [`ARO_PHASE_W-1:0] ph,
                                           input logic [`ARO_HARM_W-1:0] harm,
                                           input logic [`ARO_SAMPLE_W-1:0] offs);
      logic [`ARO_PHASE_W+`ARO_HARM_W-1:0] prod;
      logic [`ARO_PHASE_W-1:0]             p;
      prod = ph * harm;
      p = prod[`ARO_PHASE_W-1:0] + {offs, 16'h0000};
      sine_of = sine_lut(p[`ARO_PHASE_W-1 -: `ARO_LUT_AW]);
   endfunction

   function automatic aro_sample_t term_of(input logic en, input aro_mode_t md,
                                           input aro_sample_t a, input aro_sample_t sn);
      if (!en) begin
         term_of = '0;
      end else if (md == ARO_MODULATED) begin
         term_of = mul_q15(a, sn);
      end else begin
         term_of = a;
      end
   endfunction

   // carrier pick per wave output: clear takes sine 1, set takes sine 2
   function automatic aro_sample_t carrier_of(input logic sel, input aro_sample_t s1,
                                              input aro_sample_t s2);
      if (sel) begin
         carrier_of = s2;
      end else begin
         carrier_of = s1;
      end
   endfunction

   function automatic logic [`ARO_PHASE_W-1:0] osc_of(input logic sel,
                                                      input logic [`ARO_PHASE_W-1:0] o1,
                                                      input logic [`ARO_PHASE_W-1:0] o2);
      if (sel) begin
         osc_of = o2;
      end else begin
         osc_of = o1;
      end
   endfunction

   // a new routing is taken only between waits
   assign play_ready  = (wstate_q == ARO_IDLE);
   assign wait_busy   = (wstate_q == ARO_WAITING);
   assign route_mask1 = mask1_q;
   assign route_mask2 = mask2_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         mask1_q <= `ARO_DFLT_MASK1;
         mask2_q <= `ARO_DFLT_MASK2;
      end else if (play_valid && play_ready) begin
         mask1_q <= route_of(play_instr.op1, `ARO_DFLT_MASK1);
         mask2_q <= play_instr.two_waves ?
                    route_of(play_instr.op2, `ARO_DFLT_MASK2) : 2'h0;
      end
   end

   // argument counted in clock periods of this block
   always_ff @(posedge clk) begin
      if (reset) begin
         wstate_q <= ARO_IDLE;
         wcnt_q   <= '0;
      end else begin
         case (wstate_q)
            ARO_IDLE: begin
               if (wait_valid && wait_cycles != '0) begin
                  wstate_q <= ARO_WAITING;
                  wcnt_q   <= wait_cycles - 1'b1;
               end
            end
            ARO_WAITING: begin
               if (wcnt_q == '0) begin
                  wstate_q <= ARO_IDLE;
               end else begin
                  wcnt_q <= wcnt_q - 1'b1;
               end
            end
            default: wstate_q <= ARO_IDLE;
         endcase
      end
   end

   // free running so carriers stay phase coherent
   always_ff @(posedge clk) begin
      if (reset) begin
         osc1_q <= '0;
         osc2_q <= '0;
      end else begin
         osc1_q <= osc1_q + osc_freq1;
         osc2_q <= osc2_q + osc_freq2;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sine1_q <= '0;
      end else if (multi_freq_present) begin
         sine1_q <= sine_of(osc_of(sine_osc_sel[0], osc1_q, osc2_q),
                            sine_harmonic1, sine_phase_offset1);
      end else begin
         sine1_q <= sine_of(osc1_q, sine_harmonic1, sine_phase_offset1);
      end
   end

   // without the option each sine generator is tied to its own oscillator
   always_ff @(posedge clk) begin
      if (reset) begin
         sine2_q <= '0;
      end else if (multi_freq_present) begin
         sine2_q <= sine_of(osc_of(sine_osc_sel[1], osc1_q, osc2_q),
                            sine_harmonic2, sine_phase_offset2);
      end else begin
         sine2_q <= sine_of(osc2_q, sine_harmonic2, sine_phase_offset2);
      end
   end

   // amplitude belongs to the core output, not the channel
   assign amp1 = mul_q15(core_sample1, full_scale_amplitude1);
   assign amp2 = mul_q15(core_sample2, full_scale_amplitude2);

   always_comb begin
      t11 = term_of(mask1_q[0], mode1, amp1, carrier_of(mod_sel1[0], sine1_q, sine2_q));
      t12 = term_of(mask1_q[1], mode1, amp1, carrier_of(mod_sel1[1], sine1_q, sine2_q));
      t21 = term_of(mask2_q[0], mode2, amp2, carrier_of(mod_sel2[0], sine1_q, sine2_q));
      t22 = term_of(mask2_q[1], mode2, amp2, carrier_of(mod_sel2[1], sine1_q, sine2_q));
      mix.ch1 = sat_add(t11, t21);
      mix.ch2 = sat_add(t12, t22);
   end

   // converter stall reaches the sample source through this ready
   assign sample_ready = fifo_in_ready;

   aro_fifo #(
      .WIDTH (2*`ARO_SAMPLE_W),
      .DEPTH (`ARO_FIFO_DEPTH),
      .AW    (`ARO_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (sample_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (mix),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );
endmodule
